// file: iscd_bus_peer.sv
// Other masters on the bus: open-drain pulls and a rival link clock.
`timescale 1ns/1ps
`default_nettype none
module iscd_bus_peer (
  input wire logic sda_oe_n,
  input wire logic scl_oe_n,
  input wire logic hold_sda,
  input wire logic run_scl,
  output wire logic sda_line,
  output wire logic scl_line
);
  logic scl_q;
  // Rival link clock, parked high between frames.
  // A rival master clocks out a one.
  initial begin
    scl_q = 1'b1;
    forever begin
      #80;
      scl_q = run_scl ? !scl_q : 1'b1;
    end
  end
  // Pull-ups lift a released line; any driver wins low.
  // A rival may pull data low first.
  assign sda_line = sda_oe_n && !hold_sda;
  assign scl_line = scl_oe_n && scl_q;
endmodule
`default_nettype wire

// file: iscd_consts.vh
// Offsets, field positions, reset values and timing counts for the START collision block.
`ifndef ISCD_CONSTS_VH
`define ISCD_CONSTS_VH
`define ISCD_OFF_FLAG 12'h000
`define ISCD_OFF_ENABLE 12'h004
`define ISCD_OFF_PRIO 12'h008
`define ISCD_OFF_CTRL 12'h00c
`define ISCD_OFF_RELOAD 12'h010
`define ISCD_OFF_STATUS 12'h014
`define ISCD_BIT_COLL 3
`define ISCD_FLAG_MASK 8'h1e
`define ISCD_FLAG_RST 8'h00
`define ISCD_ENABLE_RST 8'h00
`define ISCD_PRIO_RST 8'h1f
`define ISCD_RELOAD_RST 7'h04
`define ISCD_RELOAD_W 7
// Clocks a released line needs to reach the sequencer: drive flop, pin flop and two synchroniser flops.
`define ISCD_SETTLE_CYC 3'h4
`endif

// file: iscd_rate_counter.v
// Reload-and-count-down rate counter that times each START phase.
`timescale 1ns/1ps
`default_nettype none
module iscd_rate_counter #(
  parameter W = 7
) (
  input wire mclk,
  input wire nrst,
  input wire load,
  input wire clear,
  input wire [W-1:0] reload,
  output reg [W-1:0] count_q,
  output wire expired
);
  // Load wins over clear; otherwise count down and rest at zero.
  always @(posedge mclk) begin
    if (!nrst) begin
      count_q <= {W{1'b0}};
    end else if (load) begin
      count_q <= reload;
    end else if (clear) begin
      count_q <= {W{1'b0}};
    end else if (count_q != {W{1'b0}}) begin
      count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign expired = (count_q == {W{1'b0}});
endmodule
`default_nettype wire

// file: iscd_start_collision.v
// START generator with bus collision detect, flag, enable and priority registers over APB.
//
// What this block does
// - Both data and clock lines are watched from the check until the first countdown ends.
// - Either line still low after the settle time: abort, set collision flag, return to idle.
// - Lines released; data seen high loads the rate counter from reload bits 6:0.
// - Clock low while data high in first countdown is a collision.
// - Data low in first countdown: reload counter and pull data low at once.
// - Data still high at first expiry: drive data low then.
// - Reload and count again; clock low here is not a collision.
// - At second expiry drive clock low, completing the START.
// - Another master pulling data low first is no collision; arbitration continues.
// - Collision flag sits in bit 3 of the flag register until software clears it.
`timescale 1ns/1ps
`default_nettype none
`include "iscd_consts.vh"
module iscd_start_collision (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  output reg irq_high,
  output reg irq_low,
  output reg irq
);
  // Register map, one 32-bit word per register, live bits at the bottom:
  //   0x000 flag register: bit 3 is the sticky bus collision flag, write one to clear.
  //   0x004 enable register: bit 3 lets the collision flag raise the interrupt.
  //   0x008 priority register: bit 3 steers the request to the high or low level output.
  //   0x00c control register: writing bit 0 as one asks for a START while idle.
  //   0x010 reload register: bits 6:0 set the length of each START phase in clocks.
  //   0x014 status register: bit 0 idle, bit 1 clock line low, bit 2 START done,
  //         bits 9:3 the rate counter value.
  // Bits 4:1 of the enable and priority registers are writable; priority leaves reset as 0x1f.
  // A reload value of zero makes each phase end after a single clock.
  // Any other address answers with an error and leaves every register untouched.
  //
  // A START runs as follows. The request releases both lines and waits a few clocks,
  // so that the released level has crossed the pin path and the synchronisers.
  // Either line still low then counts as a collision. Otherwise the rate counter is
  // loaded and counts down while the data line stays high; the clock line falling in
  // that time is a collision. The data line falling early, another master starting
  // first, is no collision: the block pulls data low at once and arbitration goes on.
  // The second count ends with the clock line pulled low, and both lines then stay
  // held until the next START request releases them.
  //
  // The bus side answers every transfer after one setup cycle, so each access takes
  // exactly two clocks; read data and the error flag are registered.
  //
  // A collision and a software clear in the same clock leave the flag set, so that no
  // event is lost.

  // One-hot sequencer states.
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CHECK = 5'b00010;
  localparam [4:0] ST_WAIT_SDA = 5'b00100;
  localparam [4:0] ST_CNT1 = 5'b01000;
  localparam [4:0] ST_CNT2 = 5'b10000;

  // Sequencer and software-visible registers.
  reg [4:0] state_q;
  reg [7:0] flag_q;
  reg [7:0] enable_q;
  reg [7:0] prio_q;
  reg [6:0] reload_q;
  reg start_req_q;
  reg done_q;
  reg [2:0] settle_q;
  reg sda_drive_q;
  reg scl_drive_q;
  // Combinational controls from the sequencer.
  reg cnt_load;
  reg cnt_clear;
  reg coll_event;
  reg done_event;
  reg [4:0] state_d;
  // Synchronised lines, counter taps and bus decode.
  wire sda_s;
  wire scl_s;
  wire [6:0] cnt_value;
  wire cnt_expired;
  wire wr_acc;
  wire [7:0] flag_rd;
  wire coll_pending;

  // Bring the bus lines into the clock domain before any logic looks at them.
  iscd_sync u_sync_sda (
    .mclk(mclk),
    .nrst(nrst),
    .din(sda_in),
    .dout_q(sda_s)
  );

  iscd_sync u_sync_scl (
    .mclk(mclk),
    .nrst(nrst),
    .din(scl_in),
    .dout_q(scl_s)
  );

  // Rate counter that times both phases of the START.
  iscd_rate_counter #(
    .W(`ISCD_RELOAD_W)
  ) u_rate (
    .mclk(mclk),
    .nrst(nrst),
    .load(cnt_load),
    .clear(cnt_clear),
    .reload(reload_q),
    .count_q(cnt_value),
    .expired(cnt_expired)
  );

  // A write takes effect at the edge that ends the access cycle.
  assign wr_acc = psel & penable & pwrite;

  // Sequencer next state, counter controls and collision detection.
  always @* begin
    state_d = state_q;
    cnt_load = 1'b0;
    cnt_clear = 1'b0;
    coll_event = 1'b0;
    done_event = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // A request is only taken while idle, so a running START is never restarted.
        if (start_req_q) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Released lines need the settle time before their level counts.
        // busy bus aborts
        if (settle_q != 3'h0) begin
          state_d = ST_CHECK;
        end else if (!sda_s || !scl_s) begin
          coll_event = 1'b1;
          state_d = ST_IDLE;
        end else begin
          state_d = ST_WAIT_SDA;
        end
      end
      ST_WAIT_SDA: begin
        if (!scl_s) begin
          coll_event = 1'b1;
          state_d = ST_IDLE;
        end else if (sda_s) begin
          cnt_load = 1'b1;
          state_d = ST_CNT1;
        end
      end
      ST_CNT1: begin
        if (!sda_s) begin
          cnt_clear = 1'b1;
          cnt_load = 1'b1;
          state_d = ST_CNT2;
        end else if (!scl_s) begin
          coll_event = 1'b1;
          state_d = ST_IDLE;
        end else if (cnt_expired) begin
          cnt_load = 1'b1;
          state_d = ST_CNT2;
        end
      end
      ST_CNT2: begin
        if (cnt_expired) begin
          done_event = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and line drive; the line drive holds after a completed START.
  always @(posedge mclk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      settle_q <= 3'h0;
      sda_drive_q <= 1'b0;
      scl_drive_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Start the settle count with the request; it runs out inside the check state.
      if (start_req_q && (state_q == ST_IDLE)) begin
        settle_q <= `ISCD_SETTLE_CYC;
      end else if (settle_q != 3'h0) begin
        settle_q <= settle_q - 3'h1;
      end
      if (coll_event) begin
        sda_drive_q <= 1'b0;
        scl_drive_q <= 1'b0;
      end else if (state_q == ST_CHECK) begin
        sda_drive_q <= 1'b0;
        scl_drive_q <= 1'b0;
      end else if ((state_q == ST_CNT1) && (state_d == ST_CNT2)) begin
        sda_drive_q <= 1'b1;
      end else if (done_event) begin
        scl_drive_q <= 1'b1;
      end
      // The done bit holds until the next START is checked.
      if (done_event) begin
        done_q <= 1'b1;
      end else if (state_q == ST_CHECK) begin
        done_q <= 1'b0;
      end
    end
  end

  // Pin outputs: open drain, enable low while pulling the line low.
  always @(posedge mclk) begin
    if (!nrst) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
    end else begin
      // The out values stay low; only the enables move, as the lines are open drain.
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe_n <= ~sda_drive_q;
      scl_oe_n <= ~scl_drive_q;
    end
  end

  // Control register writes: reload value, start request, enable and priority.
  always @(posedge mclk) begin
    if (!nrst) begin
      enable_q <= `ISCD_ENABLE_RST;
      prio_q <= `ISCD_PRIO_RST;
      reload_q <= `ISCD_RELOAD_RST;
      start_req_q <= 1'b0;
    end else begin
      // The start request is a one-clock pulse.
      start_req_q <= 1'b0;
      if (wr_acc) begin
        if (paddr == `ISCD_OFF_ENABLE) begin
          enable_q <= pwdata[7:0] & `ISCD_FLAG_MASK;
        end else if (paddr == `ISCD_OFF_PRIO) begin
          prio_q <= pwdata[7:0] & `ISCD_FLAG_MASK;
        end else if (paddr == `ISCD_OFF_RELOAD) begin
          reload_q <= pwdata[6:0];
        end else if (paddr == `ISCD_OFF_CTRL) begin
          start_req_q <= pwdata[0] & (state_q == ST_IDLE);
        end
      end
    end
  end

  // Collision flag: set by hardware, cleared by writing one; the set wins.
  always @(posedge mclk) begin
    if (!nrst) begin
      flag_q <= `ISCD_FLAG_RST;
    end else begin
      if (coll_event) begin
        flag_q[`ISCD_BIT_COLL] <= 1'b1;
      end else if (wr_acc && (paddr == `ISCD_OFF_FLAG) && pwdata[`ISCD_BIT_COLL]) begin
        flag_q[`ISCD_BIT_COLL] <= 1'b0;
      end
    end
  end

  // Only the collision bit is live; the other flag bits stay at their reset value.
  // unimplemented bits zero
  assign flag_rd = flag_q & `ISCD_FLAG_MASK;

  // An enabled collision flag is what asks for service.
  assign coll_pending = flag_q[`ISCD_BIT_COLL] & enable_q[`ISCD_BIT_COLL];

  // Interrupt request, steered by the priority bit.
  always @(posedge mclk) begin
    if (!nrst) begin
      irq <= 1'b0;
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else begin
      irq <= coll_pending;
      irq_high <= coll_pending & prio_q[`ISCD_BIT_COLL];
      irq_low <= coll_pending & ~prio_q[`ISCD_BIT_COLL];
    end
  end

  // APB slave: no wait states, read data registered, unmapped addresses error.
  always @(posedge mclk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      // Ready follows every setup cycle, so the access cycle always completes at once.
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      // Setup cycle: decode the address and prepare the answer for the access cycle.
      if (psel && !penable) begin
        if (paddr == `ISCD_OFF_FLAG) begin
          prdata <= {24'h00_0000, flag_rd};
        end else if (paddr == `ISCD_OFF_ENABLE) begin
          prdata <= {24'h00_0000, enable_q};
        end else if (paddr == `ISCD_OFF_PRIO) begin
          prdata <= {24'h00_0000, prio_q};
        end else if (paddr == `ISCD_OFF_CTRL) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == `ISCD_OFF_RELOAD) begin
          prdata <= {25'h000_0000, reload_q};
        end else if (paddr == `ISCD_OFF_STATUS) begin
          prdata <= {22'h00_0000, cnt_value, done_q, ~scl_s, state_q == ST_IDLE};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: iscd_start_collision_bench.sv
// Self-checking bench for the START collision block.
`timescale 1ns/1ps
`default_nettype none
`include "iscd_consts.vh"
`define CHK(n, e, s) check(n, e, s)
module iscd_start_collision_bench;
  typedef struct {logic w; logic [11:0] a; logic [31:0] v; logic er;} iscd_row_t;
  logic mclk, nrst, psel, penable, pwrite, hold_sda, run_scl, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sda_out, sda_oe_n, scl_out, scl_oe_n;
  logic irq_high, irq_low, irq, sda_line, scl_line;
  int err_total, cmp_count, n;
  iscd_row_t rows [7] = '{'{1'b0, `ISCD_OFF_FLAG, 32'h0000_0000, 1'b0},
    '{1'b0, `ISCD_OFF_ENABLE, 32'h0000_0000, 1'b0}, '{1'b0, `ISCD_OFF_PRIO, 32'h0000_001f, 1'b0},
    '{1'b0, `ISCD_OFF_RELOAD, 32'h0000_0004, 1'b0}, '{1'b1, `ISCD_OFF_ENABLE, 32'h0000_001e, 1'b0},
    '{1'b1, `ISCD_OFF_FLAG, 32'h0000_0000, 1'b0}, '{1'b1, 12'h018, 32'h0000_0000, 1'b1}};
  iscd_start_collision dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .irq_high(irq_high), .irq_low(irq_low), .irq(irq));
  iscd_bus_peer peer (.sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n), .hold_sda(hold_sda), .run_scl(run_scl),
    .sda_line(sda_line), .scl_line(scl_line));
  // Clock of 8 ns.
  always #4 mclk = !mclk;
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    cmp_count++;
    if (sn !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  // One APB transfer; waits for pready, then takes data and releases.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && s !== v; k++) @(posedge mclk);
  endtask
  task automatic reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard.
  initial begin
    #100000;
    err_total++;
    conclude();
  end
  // Main sequence.
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, hold_sda, run_scl} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    reset();
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, 32'hffff_ffff);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("reg value", rows[i].v, rd);
      `CHK("reg error", rows[i].er, e);
    end
    $display("register table done");
    hold_sda <= 1'b1;
    apb(1'b1, `ISCD_OFF_CTRL, 32'h0000_0001);
    wait_sig(irq, 1'b1, 40);
    `CHK("irq high", 1'b1, irq_high);
    `CHK("data free", 1'b1, sda_oe_n);
    apb(1'b0, `ISCD_OFF_FLAG, 32'h0000_0000);
    `CHK("flag set", 32'h0000_0008, rd);
    apb(1'b1, `ISCD_OFF_PRIO, 32'h0000_0000);
    wait_sig(irq_low, 1'b1, 10);
    `CHK("irq low", 1'b1, irq_low);
    apb(1'b1, `ISCD_OFF_ENABLE, 32'h0000_0000);
    wait_sig(irq, 1'b0, 10);
    `CHK("irq masked", 1'b0, irq);
    apb(1'b1, `ISCD_OFF_ENABLE, 32'h0000_0008);
    apb(1'b1, `ISCD_OFF_FLAG, 32'h0000_0008);
    wait_sig(irq, 1'b0, 10);
    `CHK("irq cleared", 1'b0, irq);
    hold_sda <= 1'b0;
    $display("busy line test done");
    apb(1'b1, `ISCD_OFF_RELOAD, 32'h0000_007f);
    apb(1'b1, `ISCD_OFF_CTRL, 32'h0000_0001);
    repeat (8) @(posedge mclk);
    run_scl <= 1'b1;
    wait_sig(irq, 1'b1, 200);
    `CHK("clock collision", 1'b1, irq);
    `CHK("data kept", 1'b1, sda_oe_n);
    run_scl <= 1'b0;
    repeat (16) @(posedge mclk);
    apb(1'b1, `ISCD_OFF_FLAG, 32'h0000_0008);
    $display("clock collision test done");
    apb(1'b1, `ISCD_OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge mclk);
    hold_sda <= 1'b1;
    wait_sig(sda_oe_n, 1'b0, 10);
    `CHK("early data", 1'b0, sda_oe_n);
    run_scl <= 1'b1;
    wait_sig(scl_oe_n, 1'b0, 300);
    `CHK("clock pulled", 1'b0, scl_oe_n);
    apb(1'b0, `ISCD_OFF_FLAG, 32'h0000_0000);
    `CHK("no collision", 32'h0000_0000, rd);
    hold_sda <= 1'b0;
    run_scl <= 1'b0;
    $display("rival data test done");
    reset();
    apb(1'b1, `ISCD_OFF_CTRL, 32'h0000_0001);
    wait_sig(sda_oe_n, 1'b0, 100);
    `CHK("data pulled", 1'b0, sda_oe_n);
    for (n = 0; n < 100 && scl_oe_n !== 1'b0; n++) @(posedge mclk);
    `CHK("second count", 1'b1, n >= 4 && n <= 6);
    apb(1'b0, `ISCD_OFF_STATUS, 32'h0000_0000);
    `CHK("done bit", 1'b1, rd[2]);
    `CHK("pin levels", 2'b00, {sda_out, scl_out});
    $display("plain start test done");
    conclude();
  end
endmodule
`default_nettype wire

// file: iscd_start_collision_sva.sv
// Port assertions for the START collision block.
`timescale 1ns/1ps
`default_nettype none
module iscd_start_collision_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sda_oe_n,
  input wire logic scl_oe_n,
  input wire logic irq,
  input wire logic irq_high,
  input wire logic irq_low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // The bus answers one cycle after setup, for one cycle only.
  a_ready_timing: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing wrong");
  a_err_unmapped: assert property (pready && paddr > 12'h014 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_flag_zeros: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[7:5] == 3'h0 && !prdata[0])
    else $error("unused flag bits not zero");
  a_scl_last: assert property ($fell(scl_oe_n) |-> !sda_oe_n)
    else $error("clock pulled before data");
  a_scl_holds: assert property ($fell(sda_oe_n) |-> scl_oe_n)
    else $error("clock pulled with data");
  a_irq_split: assert property (irq |-> irq_high != irq_low)
    else $error("irq level split wrong");
  a_irq_only: assert property (!irq |-> !irq_high && !irq_low)
    else $error("level request without irq");
  a_lines_free: assert property ($rose(irq) |-> sda_oe_n && scl_oe_n)
    else $error("lines held after collision");
  // Main scenarios reached.
  cover property (pslverr);
  cover property ($fell(scl_oe_n));
  cover property ($rose(irq_low));
endmodule
bind iscd_start_collision iscd_start_collision_sva u_sva (.mclk(mclk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n), .irq(irq), .irq_high(irq_high), .irq_low(irq_low));
`default_nettype wire

// file: iscd_sync.v
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module iscd_sync (
  input wire mclk,
  input wire nrst,
  input wire din,
  output reg dout_q
);
  reg meta_q;

  // The first flop feeds only the second; idle bus level is high.
  always @(posedge mclk) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      dout_q <= 1'b1;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule
`default_nettype wire
